//--- src/smch_pkg.sv
// constants, layouts and types of the smart command handler
package smch_pkg;
  // command decode
  localparam logic [7:0] CMD_SMART = 8'hB0;
  localparam logic [7:0] FEAT_THR = 8'hD1;
  localparam logic [7:0] FEAT_STATUS = 8'hDA;
  localparam logic [7:0] FEAT_LOG_RD = 8'hD5;
  localparam logic [7:0] FEAT_LOG_WR = 8'hD6;
  localparam logic [7:0] FEAT_REMAP = 8'hE0;
  localparam logic [7:0] FEAT_WEAR = 8'hE1;
  localparam logic [7:0] SIG_LO = 8'h4F;
  localparam logic [7:0] SIG_HI = 8'hC2;
  localparam logic [7:0] STAT_LO = 8'hF4;
  localparam logic [7:0] STAT_HI_BAD = 8'h2C;
  localparam logic [7:0] STAT_HI_OK = 8'hC2;
  // log addresses and sizes in sectors
  localparam logic [7:0] LOG_DIR = 8'h00;
  localparam logic [7:0] LOG_HOST_LO = 8'h80;
  localparam logic [7:0] LOG_HOST_HI = 8'h9F;
  localparam logic [7:0] LOG_WEAR = 8'hA0;
  localparam logic [7:0] LOG_REMAP = 8'hA1;
  localparam logic [7:0] LOG_RSVD = 8'hA2;
  localparam logic [7:0] SECS_HOST = 8'h10;
  localparam logic [7:0] SECS_WEAR = 8'h04;
  localparam logic [7:0] SECS_ONE = 8'h01;
  // 16-bit word positions inside sectors
  localparam logic [15:0] DIR_VERSION = 16'h0001;
  localparam logic [12:0] DIR_W_HOST_LO = 13'h0080;
  localparam logic [12:0] DIR_W_HOST_HI = 13'h009F;
  localparam logic [12:0] DIR_W_WEAR = 13'h00A0;
  localparam logic [12:0] DIR_W_REMAP = 13'h00A1;
  localparam logic [12:0] DIR_W_RSVD = 13'h00A2;
  localparam logic [12:0] REMAP_W_CUR = 13'h0010;
  localparam logic [12:0] REMAP_W_END = 13'h0020;
  localparam logic [12:0] WEAR_W_ENTRY = 13'h0004;
  localparam logic [31:0] WEAR_MARKER = 32'h0FFFFFFF;
  localparam logic [12:0] SECTOR_WORDS = 13'h0100;
  // threshold sector layout
  localparam logic [7:0] THR_VER_LO = 8'h10;
  localparam logic [8:0] THR_B_ENTRY = 9'h002;
  localparam logic [8:0] THR_ENTRY_LEN = 9'h00C;
  localparam logic [8:0] THR_B_CSUM = 9'h1FF;
  localparam int THR_ENTRIES = 12;
  // entry ids, entry 0 first: 196 213 229 203 204 199 232 12 241 242 214 215
  localparam logic [95:0] THR_IDS = 96'hD7D6F2F10CE8C7CCCBE5D5C4;
  localparam logic [3:0] THR_E_SPARE = 4'h0;
  localparam logic [3:0] THR_E_ERASE = 4'h2;
  localparam logic [7:0] THR_FIXED_SUM = 8'h70; // ids plus version, mod 256
  localparam logic [9:0] WEAR_CLASS_MAX = 10'h3FF;
  localparam int HOST_WORDS = 131072;
  // data source of a read transfer
  typedef enum logic [2:0] {SRC_THR, SRC_DIR, SRC_HOST, SRC_WEAR, SRC_REMAP, SRC_ZERO} smch_src_t;
  // transfer states
  typedef enum logic [3:0] {ST_IDLE = 4'h1, ST_RD = 4'h2, ST_WR = 4'h4, ST_END = 4'h8} smch_st_t;
endpackage

//--- src/smch_core.sv
// smart command handler: task-file decode, sector generation, host logs
`timescale 1ns/1ps
module smch_core (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_command,
  input wire logic [7:0] i_feature,
  input wire logic [7:0] i_sec_count,
  input wire logic [7:0] i_sec_number,
  input wire logic [7:0] i_cyl_lo,
  input wire logic [7:0] i_cyl_hi,
  input wire logic i_smart_en,
  input wire logic [7:0] i_spare_thr,
  input wire logic [7:0] i_erase_thr,
  input wire logic [7:0] i_spare_attr,
  input wire logic [7:0] i_erase_attr,
  input wire logic [255:0] i_remap_init,
  input wire logic [255:0] i_remap_cur,
  input wire logic [15:0] i_wear_low,
  input wire logic [15:0] i_wear_high,
  input wire logic [31:0] i_wear_blocks,
  input wire logic [15:0] i_wear_thr,
  input wire logic i_blk_erase,
  input wire logic i_blk_clear,
  input wire logic i_rd_ready,
  input wire logic i_wr_valid,
  input wire logic [15:0] i_wr_data,
  output logic o_busy,
  output logic o_done,
  output logic o_abort,
  output logic [7:0] o_cyl_lo,
  output logic [7:0] o_cyl_hi,
  output logic o_rd_valid,
  output logic [15:0] o_rd_data,
  output logic o_wr_ready,
  output logic [9:0] o_wear_class,
  output logic [9:0] o_blk_class
);
  import smch_pkg::*;
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    smch_st_t st;
    smch_src_t src;
    logic [4:0] host_log;
    logic [12:0] cnt, limit;
    logic rd_valid, done, abort;
    logic [15:0] rd_data, residue;
    logic [7:0] cyl_lo, cyl_hi;
    logic [9:0] blk_class;
  } smch_state_t;
  smch_state_t s_q, s_d;
  logic [15:0] host_mem [0:HOST_WORDS-1];
  logic sig_ok, exceeded, wr_take, entry_used;
  logic [15:0] word, entry_class;
  logic [16:0] host_addr;
  logic [7:0] b_lo, b_hi, entry_idx;
  // ------------------------------------------------------------
  // threshold sector byte generator
  // ------------------------------------------------------------
  function automatic logic [7:0] thr_byte(input logic [8:0] b, input logic [7:0] sp, input logic [7:0] er);
    logic [8:0] rel;
    logic [5:0] e, o;
    rel = b - THR_B_ENTRY;
    e = 6'(rel / THR_ENTRY_LEN); // full quotient: a narrow index wraps and repeats ids
    o = 6'(rel % THR_ENTRY_LEN);
    thr_byte = 8'h00;
    if (b == 9'h000) begin
      thr_byte = THR_VER_LO;
    end else if (b == THR_B_CSUM) begin
      thr_byte = 8'(8'h00 - THR_FIXED_SUM - sp - er);
    end else if (b >= THR_B_ENTRY && int'(e) < THR_ENTRIES) begin
      if (o == 6'h00) begin
        thr_byte = THR_IDS[8*e +: 8];
      end else if (o == 6'h01 && e == 6'(THR_E_SPARE)) begin
        thr_byte = sp;
      end else if (o == 6'h01 && e == 6'(THR_E_ERASE)) begin
        thr_byte = er;
      end
    end
  endfunction
  // ------------------------------------------------------------
  // decode helpers and read word generator
  // ------------------------------------------------------------
  // signature and enable check
  assign sig_ok = (i_command == CMD_SMART) && (i_cyl_lo == SIG_LO) && (i_cyl_hi == SIG_HI) && i_smart_en;
  assign exceeded = (i_spare_attr < i_spare_thr) || (i_erase_attr < i_erase_thr);
  assign host_addr = {s_q.host_log, s_q.cnt[11:0]};
  assign wr_take = (s_q.st == ST_WR) && i_wr_valid && (s_q.cnt < s_q.limit);
  assign b_lo = thr_byte({s_q.cnt[7:0], 1'b0}, i_spare_thr, i_erase_thr);
  assign b_hi = thr_byte({s_q.cnt[7:0], 1'b1}, i_spare_thr, i_erase_thr);
  // entry k of the wear data names class low+k-1
  assign entry_idx = 8'((s_q.cnt[9:0] - 10'(WEAR_W_ENTRY)) >> 2);
  assign entry_class = i_wear_low + 16'(entry_idx);
  assign entry_used = (entry_class <= i_wear_high) && (entry_class <= 16'(WEAR_CLASS_MAX));
  assign o_wear_class = entry_class[9:0];
  // data word for the current read position
  always_comb begin
    word = 16'h0000;
    case (s_q.src)
      SRC_THR: word = {b_hi, b_lo};
      SRC_DIR: begin
        if (s_q.cnt == 13'h0000) begin
          word = DIR_VERSION;
        end else if (s_q.cnt >= DIR_W_HOST_LO && s_q.cnt <= DIR_W_HOST_HI) begin
          word = 16'(SECS_HOST);
        end else if (s_q.cnt == DIR_W_WEAR) begin
          word = 16'(SECS_WEAR);
        end else if (s_q.cnt == DIR_W_REMAP || s_q.cnt == DIR_W_RSVD) begin
          word = 16'(SECS_ONE);
        end
      end
      SRC_HOST: word = host_mem[host_addr];
      SRC_REMAP: begin
        if (s_q.cnt < REMAP_W_CUR) begin
          word = i_remap_init[16*s_q.cnt[3:0] +: 16];
        end else if (s_q.cnt < REMAP_W_END) begin
          word = i_remap_cur[16*s_q.cnt[3:0] +: 16];
        end
      end
      SRC_WEAR: begin
        if (s_q.cnt < WEAR_W_ENTRY) begin
          case (s_q.cnt[1:0])
            2'h0: word = WEAR_MARKER[15:0];
            2'h1: word = WEAR_MARKER[31:16];
            2'h2: word = i_wear_low;
            default: word = i_wear_high;
          endcase
        end else if (entry_used) begin
          case (s_q.cnt[1:0])
            2'h0: word = entry_class;
            2'h1: word = 16'h0000;
            2'h2: word = i_wear_blocks[15:0];
            default: word = i_wear_blocks[31:16];
          endcase
        end
      end
      default: word = 16'h0000;
    endcase
  end
  // ------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    {s_d.done, s_d.abort} = 2'b00;
    case (s_q.st)
      ST_IDLE: begin
        if (i_cmd_valid) begin
          s_d.cnt = 13'h0000;
          s_d.limit = {i_sec_count[4:0], 8'h00};
          s_d.host_log = i_sec_number[4:0];
          // abort by default, no data phase
          s_d.st = ST_END;
          s_d.abort = 1'b1;
          if (sig_ok) begin
            case (i_feature)
              FEAT_THR: begin
                s_d.src = SRC_THR;
                s_d.limit = SECTOR_WORDS;
                s_d.st = ST_RD;
                s_d.abort = 1'b0;
              end
              FEAT_STATUS: begin
                s_d.cyl_lo = STAT_LO;
                s_d.cyl_hi = exceeded ? STAT_HI_BAD : STAT_HI_OK;
                s_d.abort = 1'b0;
              end
              FEAT_REMAP: begin
                if (i_sec_count == SECS_ONE) begin
                  s_d.src = SRC_REMAP;
                  s_d.st = ST_RD;
                  s_d.abort = 1'b0;
                end
              end
              FEAT_WEAR: begin
                if (i_sec_count == SECS_WEAR) begin
                  s_d.src = SRC_WEAR;
                  s_d.st = ST_RD;
                  s_d.abort = 1'b0;
                end
              end
              FEAT_LOG_RD: begin
                if (i_sec_count != 8'h00) begin
                  if (i_sec_number >= LOG_HOST_LO && i_sec_number <= LOG_HOST_HI && i_sec_count <= SECS_HOST) begin
                    s_d.src = SRC_HOST;
                    s_d.st = ST_RD;
                  end else if (i_sec_number == LOG_WEAR && i_sec_count <= SECS_WEAR) begin
                    s_d.src = SRC_WEAR;
                    s_d.st = ST_RD;
                  end else if (i_sec_count == SECS_ONE && i_sec_number == LOG_DIR) begin
                    s_d.src = SRC_DIR;
                    s_d.st = ST_RD;
                  end else if (i_sec_count == SECS_ONE && i_sec_number == LOG_REMAP) begin
                    s_d.src = SRC_REMAP;
                    s_d.st = ST_RD;
                  end else if (i_sec_count == SECS_ONE && i_sec_number == LOG_RSVD) begin
                    s_d.src = SRC_ZERO;
                    s_d.st = ST_RD;
                  end
                  s_d.abort = (s_d.st != ST_RD);
                end
              end
              FEAT_LOG_WR: begin
                if (i_sec_number >= LOG_HOST_LO && i_sec_number <= LOG_HOST_HI && i_sec_count != 8'h00 &&
                    i_sec_count <= SECS_HOST) begin
                  s_d.st = ST_WR;
                  s_d.abort = 1'b0;
                end
              end
              default: s_d.abort = 1'b1;
            endcase
          end
          s_d.done = (s_d.st == ST_END);
          if (s_d.st == ST_END) begin
            s_d.st = ST_IDLE;
          end
        end
      end
      ST_RD: begin
        if (s_q.rd_valid && i_rd_ready && s_q.cnt == s_q.limit) begin
          s_d.rd_valid = 1'b0;
          s_d.done = 1'b1;
          s_d.st = ST_IDLE;
        end else if ((!s_q.rd_valid || i_rd_ready) && s_q.cnt < s_q.limit) begin
          s_d.rd_valid = 1'b1;
          s_d.rd_data = word;
          s_d.cnt = s_q.cnt + 13'h0001;
        end else if (i_rd_ready) begin
          s_d.rd_valid = 1'b0;
        end
      end
      ST_WR: begin
        if (wr_take) begin
          s_d.cnt = s_q.cnt + 13'h0001;
          if (s_d.cnt == s_q.limit) begin
            s_d.done = 1'b1;
            s_d.st = ST_IDLE;
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // wear class tracker of one block
    if (i_blk_clear) begin
      s_d.residue = 16'h0000;
      s_d.blk_class = 10'h000;
    end else if (i_blk_erase) begin
      if (s_q.residue == i_wear_thr) begin
        s_d.residue = 16'h0000;
        if (s_q.blk_class != WEAR_CLASS_MAX) begin
          s_d.blk_class = s_q.blk_class + 10'h001;
        end
      end else begin
        s_d.residue = s_q.residue + 16'h0001;
      end
    end
  end
  // state register
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (wr_take) begin
      host_mem[host_addr] <= i_wr_data;
    end
  end
  // outputs
  assign o_busy = (s_q.st != ST_IDLE);
  assign {o_done, o_abort, o_cyl_lo, o_cyl_hi} = {s_q.done, s_q.abort, s_q.cyl_lo, s_q.cyl_hi};
  assign {o_rd_valid, o_rd_data, o_blk_class} = {s_q.rd_valid, s_q.rd_data, s_q.blk_class};
  assign o_wr_ready = (s_q.st == ST_WR) && (s_q.cnt < s_q.limit);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_sig_abort: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (s_q.st == ST_IDLE && i_cmd_valid && !sig_ok) |=> (o_done && o_abort && !o_rd_valid))
    else $error("bad signature not aborted");
  a_abort_nodata: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (o_abort) |-> (o_done && !o_busy && !o_rd_valid))
    else $error("abort with data phase");
  a_status_bad: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (s_q.st == ST_IDLE && i_cmd_valid && sig_ok && i_feature == FEAT_STATUS && exceeded)
    |=> (o_cyl_lo == 8'hF4 && o_cyl_hi == 8'h2C && o_done && !o_abort))
    else $error("exceeded status wrong");
  a_status_ok: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (s_q.st == ST_IDLE && i_cmd_valid && sig_ok && i_feature == FEAT_STATUS && !exceeded)
    |=> (o_cyl_lo == 8'hF4 && o_cyl_hi == 8'hC2))
    else $error("good status wrong");
  a_remap_count: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (s_q.st == ST_IDLE && i_cmd_valid && sig_ok && i_feature == FEAT_REMAP && i_sec_count != 8'h01)
    |=> o_abort)
    else $error("remap count not checked");
  a_wear_len: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (s_q.st == ST_IDLE && i_cmd_valid && sig_ok && i_feature == FEAT_WEAR && i_sec_count == 8'h04)
    |=> (o_busy && s_q.limit == 13'h0400))
    else $error("wear length wrong");
  a_write_only_host: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (s_q.st == ST_IDLE && i_cmd_valid && i_feature == FEAT_LOG_WR &&
     (i_sec_number < 8'h80 || i_sec_number > 8'h9F)) |=> (o_abort && !o_wr_ready))
    else $error("write to read-only log");
  a_dir_version: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (s_q.st == ST_RD && s_q.src == SRC_DIR && s_q.cnt == 13'h0000 && !s_q.rd_valid)
    |=> (o_rd_valid && o_rd_data == 16'h0001))
    else $error("directory version wrong");
  a_rd_stable: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (o_rd_valid && !i_rd_ready) |=> (o_rd_valid && $stable(o_rd_data)))
    else $error("read word dropped");
  a_class_step: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (i_blk_erase && !i_blk_clear && s_q.residue == i_wear_thr && s_q.blk_class != 10'h3FF)
    |=> (o_blk_class == $past(o_blk_class) + 10'h001 && s_q.residue == 16'h0000))
    else $error("class step wrong");
endmodule // smch_core

//--- bench/smch_host.sv
// host controller model: issues smart commands and moves pio data words
`timescale 1ns/1ps
module smch_host (
  input wire logic i_sys_clk,
  input wire logic i_done,
  input wire logic i_abort,
  input wire logic i_rd_valid,
  input wire logic [15:0] i_rd_data,
  input wire logic i_wr_ready,
  output logic o_cmd_valid,
  output logic [7:0] o_command,
  output logic [7:0] o_feature,
  output logic [7:0] o_sec_count,
  output logic [7:0] o_sec_number,
  output logic [7:0] o_cyl_lo,
  output logic [7:0] o_cyl_hi,
  output logic o_rd_ready,
  output logic o_wr_valid,
  output logic [15:0] o_wr_data
);
  import smch_pkg::*;
  logic [15:0] rd_buf [0:1023];
  int n_rd;
  int n_wr;
  logic ab;
  // idle task file at time zero
  initial begin
    {o_cmd_valid, o_rd_ready, o_wr_valid, o_wr_data} = '0;
    {o_command, o_feature, o_sec_count, o_sec_number, o_cyl_lo, o_cyl_hi} = '0;
  end
  // one command and its data phase; slow stalls every other cycle
  task automatic run(input logic [7:0] f, input logic [7:0] cnt, input logic [7:0] adr, input logic [7:0] lo,
                     input logic slow, input logic [15:0] wbase);
    int k;
    logic dn;
    logic tk;
    n_rd = 0;
    n_wr = 0;
    ab = 1'b0;
    dn = 1'b0;
    tk = 1'b0;
    @(negedge i_sys_clk);
    {o_cmd_valid, o_command, o_feature, o_sec_count, o_sec_number} = {1'b1, CMD_SMART, f, cnt, adr};
    {o_cyl_lo, o_cyl_hi} = {lo, SIG_HI};
    @(negedge i_sys_clk);
    // released task file no longer shows the last value
    {o_cmd_valid, o_command, o_feature} = {1'b0, ~o_command, ~o_feature};
    {o_sec_count, o_sec_number, o_cyl_lo, o_cyl_hi} = ~{o_sec_count, o_sec_number, o_cyl_lo, o_cyl_hi};
    for (k = 0; k < 20000 && !dn; k++) begin
      o_rd_ready = !slow || k[0];
      o_wr_valid = (f == FEAT_LOG_WR) && ((o_wr_valid && !tk) || !slow || k[0]);
      o_wr_data = o_wr_valid ? wbase + 16'(n_wr) : ~(wbase + 16'(n_wr));
      @(posedge i_sys_clk);
      tk = o_wr_valid && (i_wr_ready === 1'b1);
      if (tk) n_wr++;
      if (o_rd_ready && (i_rd_valid === 1'b1)) begin
        rd_buf[n_rd[9:0]] = i_rd_data;
        n_rd++;
      end
      if (i_done === 1'b1) begin
        dn = 1'b1;
        ab = i_abort;
      end
      @(negedge i_sys_clk);
    end
    o_rd_ready = 1'b0;
    o_wr_valid = 1'b0;
  endtask
endmodule // smch_host

//--- bench/smch_core_tb.sv
// self-checking bench of the smart command handler
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module smch_core_tb;
  import smch_pkg::*;
  localparam logic [15:0] WL = 16'h0005;
  localparam logic [15:0] WH = 16'h0008;
  logic i_sys_clk, i_srst, i_cmd_valid, i_smart_en, i_blk_erase, i_blk_clear, i_rd_ready, i_wr_valid, slow;
  logic [7:0] i_command, i_feature, i_sec_count, i_sec_number, i_cyl_lo, i_cyl_hi;
  logic [7:0] i_spare_thr, i_erase_thr, i_spare_attr, i_erase_attr, o_cyl_lo, o_cyl_hi;
  logic [255:0] i_remap_init, i_remap_cur;
  logic [15:0] i_wear_thr, i_wr_data, o_rd_data;
  logic [31:0] i_wear_blocks;
  logic o_busy, o_done, o_abort, o_rd_valid, o_wr_ready;
  logic [9:0] o_wear_class, o_blk_class;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  // block count lookup follows the class asked for
  assign i_wear_blocks = {16'hB000, 6'h00, o_wear_class};
  smch_core smch_core_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_cmd_valid(i_cmd_valid), .i_command(i_command),
    .i_feature(i_feature), .i_sec_count(i_sec_count), .i_sec_number(i_sec_number), .i_cyl_lo(i_cyl_lo),
    .i_cyl_hi(i_cyl_hi), .i_smart_en(i_smart_en), .i_spare_thr(i_spare_thr), .i_erase_thr(i_erase_thr),
    .i_spare_attr(i_spare_attr), .i_erase_attr(i_erase_attr), .i_remap_init(i_remap_init), .i_remap_cur(i_remap_cur),
    .i_wear_low(WL), .i_wear_high(WH), .i_wear_blocks(i_wear_blocks), .i_wear_thr(i_wear_thr),
    .i_blk_erase(i_blk_erase), .i_blk_clear(i_blk_clear), .i_rd_ready(i_rd_ready), .i_wr_valid(i_wr_valid),
    .i_wr_data(i_wr_data), .o_busy(o_busy), .o_done(o_done), .o_abort(o_abort), .o_cyl_lo(o_cyl_lo),
    .o_cyl_hi(o_cyl_hi), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_wr_ready(o_wr_ready),
    .o_wear_class(o_wear_class), .o_blk_class(o_blk_class));
  smch_host smch_host_i (.i_sys_clk(i_sys_clk), .i_done(o_done), .i_abort(o_abort), .i_rd_valid(o_rd_valid),
    .i_rd_data(o_rd_data), .i_wr_ready(o_wr_ready), .o_cmd_valid(i_cmd_valid), .o_command(i_command),
    .o_feature(i_feature), .o_sec_count(i_sec_count), .o_sec_number(i_sec_number), .o_cyl_lo(i_cyl_lo),
    .o_cyl_hi(i_cyl_hi), .o_rd_ready(i_rd_ready), .o_wr_valid(i_wr_valid), .o_wr_data(i_wr_data));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // expected word: kind 0 remap, 1 wear, 2 directory
  function automatic logic [15:0] wexp(input int kind, input int w);
    logic [15:0] c;
    c = WL + 16'(w / 4) - 16'h0001;
    if (kind == 0) return (w < 16) ? 16'h1100 + 16'(w) : (w < 32) ? 16'h2200 + 16'(w - 16) : 16'h0000;
    if (kind == 2) return (w == 0 || w == 161 || w == 162) ? 16'h0001 : (w >= 128 && w < 160) ? 16'h0010 :
                          (w == 160) ? 16'h0004 : 16'h0000;
    if (w < 4) return (w == 0) ? 16'hFFFF : (w == 1) ? 16'h0FFF : (w == 2) ? WL : WH;
    if (c > WH || w % 4 == 1) return 16'h0000;
    return (w % 4 == 3) ? 16'hB000 : c;
  endfunction
  task automatic go(input logic [7:0] f, input logic [7:0] cnt, input logic [7:0] adr, input logic [7:0] lo,
                    input int nw, input logic ab);
    smch_host_i.run(f, cnt, adr, lo, slow, 16'h3A00);
    `CHK(smch_host_i.ab, ab)
    `CHK(smch_host_i.n_rd + smch_host_i.n_wr, nw)
    `CHK(o_busy, 1'b0)
  endtask
  task automatic chk_buf(input int kind, input int n);
    for (int i = 0; i < n; i++) `CHK(smch_host_i.rd_buf[i], wexp(kind, i))
  endtask
  task automatic t_status;
    go(FEAT_STATUS, 8'h00, 8'h00, SIG_LO, 0, 1'b0);
    `CHK({o_cyl_lo, o_cyl_hi}, {STAT_LO, STAT_HI_OK})
    i_erase_attr = 8'd29;
    go(FEAT_STATUS, 8'h00, 8'h00, SIG_LO, 0, 1'b0);
    `CHK({o_cyl_lo, o_cyl_hi}, {STAT_LO, STAT_HI_BAD})
    {i_erase_attr, i_spare_attr} = {8'd50, 8'd19};
    go(FEAT_STATUS, 8'h00, 8'h00, 8'h00, 0, 1'b1);
    go(FEAT_STATUS, 8'h00, 8'h00, SIG_LO, 0, 1'b0);
    `CHK({o_cyl_lo, o_cyl_hi}, {STAT_LO, STAT_HI_BAD})
    i_smart_en = 1'b0;
    go(FEAT_REMAP, 8'h01, 8'h00, SIG_LO, 0, 1'b1);
    i_smart_en = 1'b1;
  endtask
  task automatic t_data;
    int sum;
    logic [7:0] b;
    logic [7:0] e;
    go(FEAT_REMAP, 8'h02, 8'h00, SIG_LO, 0, 1'b1);
    slow = 1'b1;
    go(FEAT_REMAP, 8'h01, 8'h00, SIG_LO, 256, 1'b0);
    chk_buf(0, 256);
    slow = 1'b0;
    go(FEAT_LOG_RD, 8'h01, LOG_REMAP, SIG_LO, 256, 1'b0);
    chk_buf(0, 256);
    go(FEAT_WEAR, 8'h03, 8'h00, SIG_LO, 0, 1'b1);
    go(FEAT_WEAR, 8'h04, 8'h00, SIG_LO, 1024, 1'b0);
    chk_buf(1, 1024);
    go(FEAT_LOG_RD, 8'h04, LOG_WEAR, SIG_LO, 1024, 1'b0);
    chk_buf(1, 1024);
    go(FEAT_LOG_RD, 8'h01, LOG_DIR, SIG_LO, 256, 1'b0);
    chk_buf(2, 256);
    go(FEAT_LOG_RD, 8'h02, LOG_DIR, SIG_LO, 0, 1'b1);
    go(FEAT_LOG_RD, 8'h01, 8'h40, SIG_LO, 0, 1'b1);
    go(FEAT_LOG_RD, 8'h01, LOG_RSVD, SIG_LO, 256, 1'b0);
    for (int i = 0; i < 256; i++) `CHK(smch_host_i.rd_buf[i], 16'h0000)
    go(FEAT_THR, 8'h01, 8'h00, SIG_LO, 256, 1'b0);
    sum = 0;
    for (int i = 0; i < 512; i++) begin
      b = smch_host_i.rd_buf[i / 2][8 * (i % 2) +: 8];
      sum += b;
      e = (i == 0) ? THR_VER_LO : (i < 2 || i >= 146) ? 8'h00 : ((i - 2) % 12 == 0) ? THR_IDS[8 * ((i - 2) / 12) +: 8] :
          ((i - 2) % 12 != 1) ? 8'h00 : (i == 3) ? i_spare_thr : (i == 27) ? i_erase_thr : 8'h00;
      if (i < 511) `CHK(b, e)
    end
    `CHK(sum[7:0], 8'h00)
  endtask
  task automatic t_log;
    go(FEAT_LOG_WR, 8'h02, LOG_HOST_HI, SIG_LO, 512, 1'b0);
    go(FEAT_LOG_RD, 8'h02, LOG_HOST_HI, SIG_LO, 512, 1'b0);
    for (int i = 0; i < 512; i++) `CHK(smch_host_i.rd_buf[i], 16'h3A00 + 16'(i))
    go(FEAT_LOG_WR, 8'h01, LOG_WEAR, SIG_LO, 0, 1'b1);
    go(FEAT_LOG_WR, 8'h01, LOG_HOST_LO, 8'h00, 0, 1'b1);
    go(FEAT_LOG_RD, 8'h11, LOG_HOST_LO, SIG_LO, 0, 1'b1);
    go(FEAT_LOG_RD, 8'h10, LOG_HOST_LO, SIG_LO, 4096, 1'b0);
  endtask
  task automatic t_track;
    for (int n = 0; n < 5; n++) begin
      @(negedge i_sys_clk);
      {i_blk_erase, i_blk_clear} = {n != 4, n == 4};
      @(negedge i_sys_clk);
      {i_blk_erase, i_blk_clear} = 2'b00;
      `CHK(o_blk_class, (n == 3) ? 10'h001 : 10'h000)
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // clock and cycle ceiling
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish;
    end
  end
  // main sequence
  initial begin
    {i_srst, i_smart_en, i_blk_erase, i_blk_clear, slow} = 5'b11000;
    {i_spare_thr, i_erase_thr, i_spare_attr, i_erase_attr} = {8'd20, 8'd30, 8'd50, 8'd30};
    i_wear_thr = 16'h0003;
    for (int n = 0; n < 16; n++) {i_remap_init[16 * n +: 16], i_remap_cur[16 * n +: 16]} = {16'h1100 + 16'(n), 16'h2200 + 16'(n)};
    repeat (8) @(negedge i_sys_clk);
    i_srst = 1'b0;
    t_status();
    t_data();
    t_log();
    t_track();
    tally_and_finish();
  end
endmodule // smch_core_tb
